// >>> verilog/servo_alarm_regs.vh
// constants for the servo alarm reporting block
`ifndef SERVO_ALARM_REGS_VH
`define SERVO_ALARM_REGS_VH
// alarm code patterns, bit0 = line 1, bit1 = line 2, bit2 = line 3
`define CODE_ALL_OFF 3'h0
`define CODE_OVERCURRENT 3'h1
`define CODE_REGEN 3'h3
`define CODE_OVERVOLTAGE 3'h4
// source index positions in the fault vector
`define SRC_PARAM_CORRUPT 0
`define SRC_MAIN_DETECT 1
`define SRC_PARAM_SETTING 2
`define SRC_MOTOR_MISMATCH 3
`define SRC_OVERCURRENT 4
`define SRC_REGEN_DAMAGE 5
`define SRC_REGEN_OVERLOAD 6
`define SRC_SUPPLY_SETTING 7
`define SRC_OVERVOLTAGE 8
`define NUM_SOURCES 9
// sources that only a power cycle may clear
`define POWER_ONLY_MASK 9'h015
// servo-on source setting that forces the drive on
`define SERVO_ON_ALWAYS 4'h7
`endif

// >>> verilog/input_sync.v
// two-flop synchroniser for a vector of pin inputs
`timescale 1ns/1ps
module input_sync #(
	parameter WIDTH = 1
) (
	input wire i_ref_clk,
	input wire i_rst_n,
	input wire [WIDTH-1:0] i_async,
	output reg [WIDTH-1:0] o_sync
);
	reg [WIDTH-1:0] stage1;
	always @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			stage1 <= {WIDTH{1'b0}};
			o_sync <= {WIDTH{1'b0}};
		end else begin
			stage1 <= i_async;
			o_sync <= stage1;
		end
	end
endmodule

// >>> verilog/servo_alarm_reporting.v
// fault latching, coding and cancellation, and unlatched warning reporting, for a servo drive
`timescale 1ns/1ps
`include "servo_alarm_regs.vh"
// Contract
// - On any error the block raises the alarm, drives its code, turns off the power stage and shows it.
// - On a warning the block raises the warning flag and code and shows it while the drive keeps running.
// - Warning flag and warning code appear only when their configuration settings enable them.
// - An alarm is cleared by the reset input, by a power cycle, or by the reset key or both arrow keys.
// - Parameter corruption, parameter setting error and overcurrent clear only by a power cycle.
// - With run active or servo-on forced by setting 7 the drive resumes right after the alarm clears.
// - A failed parameter checksum raises an alarm with all three code lines off.
// - Main circuit detection error, parameter setting error and motor mismatch code all lines off.
// - Overcurrent codes line one on, lines two and three off.
// - Regeneration damage, regeneration overload and supply setting mismatch code lines one and two on.
// - Overvoltage codes lines one and two off and line three on.
// - The alarm flag is off while an alarm is active and on only when the drive is fault-free.
module servo_alarm_reporting (
	input wire i_ref_clk,
	input wire i_nrst,
	input wire [`NUM_SOURCES-1:0] i_fault_detect,
	input wire i_warn_detect,
	input wire [2:0] i_warn_code,
	input wire i_alarm_reset,
	input wire i_key_reset,
	input wire i_key_up,
	input wire i_key_down,
	input wire i_run,
	input wire [3:0] i_servo_on_source_select,
	input wire i_caution_output_select,
	input wire i_caution_code_enable,
	output reg o_fault_flag_out,
	output reg o_fault_code_line_1,
	output reg o_fault_code_line_2,
	output reg o_fault_code_line_3,
	output reg o_caution_flag_out,
	output reg o_power_stage_enable,
	output reg o_display_alarm,
	output reg o_display_warning,
	output reg [3:0] o_display_source
);
	localparam ST_IDLE = 2'b01;
	localparam ST_ALARM = 2'b10;

	reg rst_meta;
	reg rst_n;
	always @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	localparam SW = `NUM_SOURCES + 10;
	wire [SW-1:0] sync_in;
	wire [SW-1:0] sync_out;
	assign sync_in = {i_fault_detect, i_warn_detect, i_warn_code, i_alarm_reset, i_key_reset, i_key_up,
		i_key_down, i_run, i_caution_output_select};
	input_sync #(.WIDTH(SW)) u_sync (
		.i_ref_clk(i_ref_clk),
		.i_rst_n(rst_n),
		.i_async(sync_in),
		.o_sync(sync_out)
	);
	wire [`NUM_SOURCES-1:0] faults = sync_out[SW-1:10];
	wire warn_s = sync_out[9];
	wire [2:0] warn_code_s = sync_out[8:6];
	wire reset_in_s = sync_out[5];
	wire key_reset_s = sync_out[4];
	wire key_up_s = sync_out[3];
	wire key_down_s = sync_out[2];
	wire run_s = sync_out[1];
	wire caution_sel_s = sync_out[0];

	// settings rarely change but still come from pins, so they take the same two-flop path
	wire [4:0] cfg_in;
	wire [4:0] cfg_out;
	assign cfg_in = {i_servo_on_source_select, i_caution_code_enable};
	input_sync #(.WIDTH(5)) u_cfg_sync (
		.i_ref_clk(i_ref_clk),
		.i_rst_n(rst_n),
		.i_async(cfg_in),
		.o_sync(cfg_out)
	);
	wire [3:0] servo_on_sel_s = cfg_out[4:1];
	wire code_enable_s = cfg_out[0];

	// code pattern for one source
	function [2:0] code_of;
		input [3:0] src;
		begin
			case (src)
				`SRC_OVERCURRENT: code_of = `CODE_OVERCURRENT;
				`SRC_REGEN_DAMAGE, `SRC_REGEN_OVERLOAD, `SRC_SUPPLY_SETTING: code_of = `CODE_REGEN;
				`SRC_OVERVOLTAGE: code_of = `CODE_OVERVOLTAGE;
				default: code_of = `CODE_ALL_OFF;
			endcase
		end
	endfunction

	// lowest index wins when several faults arrive together
	reg [3:0] first_src;
	integer k;
	always @* begin
		first_src = 4'h0;
		for (k = `NUM_SOURCES - 1; k >= 0; k = k - 1) begin
			if (faults[k]) begin
				first_src = k[3:0];
			end
		end
	end

	reg [1:0] state;
	reg [1:0] next_state;
	reg [3:0] alarm_src;
	reg cancel_prev;
	wire any_fault = |faults;
	// level-to-edge so a held reset button cancels only once
	wire cancel_level = reset_in_s | key_reset_s | (key_up_s & key_down_s);
	wire cancel_edge = cancel_level & ~cancel_prev;
	wire [`NUM_SOURCES-1:0] power_only = `POWER_ONLY_MASK;
	wire src_power_only = power_only[alarm_src];
	wire cancel_ok = cancel_edge & ~src_power_only;
	wire servo_req = run_s | (servo_on_sel_s == `SERVO_ON_ALWAYS);
	wire warn_shown = warn_s & caution_sel_s;
	wire warn_code_shown = warn_s & code_enable_s;

	always @* begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (any_fault) begin
					next_state = ST_ALARM;
				end
			end
			ST_ALARM: begin
				// a cancel is ignored while any fault is still present; the alarm and its source stay latched
				if (cancel_ok & ~any_fault) begin
					next_state = ST_IDLE;
				end
			end
			default: next_state = ST_IDLE;
		endcase
	end

	reg [2:0] next_code;
	always @* begin
		if (next_state == ST_ALARM) begin
			next_code = code_of(next_state != state ? first_src : alarm_src);
		end else if (warn_code_shown) begin
			next_code = warn_code_s;
		end else begin
			next_code = `CODE_ALL_OFF;
		end
	end

	// next output values, registered below so every port leaves a flop
	reg next_fault_flag;
	reg next_caution_flag;
	reg next_power_stage;
	reg next_display_alarm;
	reg next_display_warning;
	reg [3:0] next_display_source;
	always @* begin
		next_fault_flag = (next_state == ST_IDLE);
		// caution flag drops in alarm so a host cannot read it as the only fault sign
		next_caution_flag = (next_state == ST_IDLE) & warn_shown;
		// warnings keep the stage on; resume is immediate after clear
		next_power_stage = (next_state == ST_IDLE) & servo_req;
		next_display_alarm = (next_state == ST_ALARM);
		next_display_warning = (next_state == ST_IDLE) & warn_s;
		next_display_source = (state == ST_IDLE) ? first_src : alarm_src;
	end

	// fault state and cancel edge history
	always @(posedge i_ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_IDLE;
			alarm_src <= 4'h0;
			cancel_prev <= 1'b0;
		end else begin
			state <= next_state;
			cancel_prev <= cancel_level;
			if (state == ST_IDLE && next_state == ST_ALARM) begin
				alarm_src <= first_src;
			end
		end
	end

	// code lines, shared by alarm and warning codes
	always @(posedge i_ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_fault_code_line_1 <= 1'b0;
			o_fault_code_line_2 <= 1'b0;
			o_fault_code_line_3 <= 1'b0;
		end else begin
			o_fault_code_line_1 <= next_code[0];
			o_fault_code_line_2 <= next_code[1];
			o_fault_code_line_3 <= next_code[2];
		end
	end

	// flags, power stage and display
	always @(posedge i_ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_fault_flag_out <= 1'b0;
			o_caution_flag_out <= 1'b0;
			o_power_stage_enable <= 1'b0;
			o_display_alarm <= 1'b0;
			o_display_warning <= 1'b0;
			o_display_source <= 4'h0;
		end else begin
			o_fault_flag_out <= next_fault_flag;
			o_caution_flag_out <= next_caution_flag;
			o_power_stage_enable <= next_power_stage;
			o_display_alarm <= next_display_alarm;
			o_display_warning <= next_display_warning;
			o_display_source <= next_display_source;
		end
	end
endmodule

// >>> tb/servo_alarm_properties.sv
// assertions on the ports of the servo alarm block
`timescale 1ns/1ps
module servo_alarm_properties (
	input wire i_ref_clk,
	input wire i_nrst,
	input wire [8:0] i_fault_detect,
	input wire i_run,
	input wire [3:0] i_servo_on_source_select,
	input wire i_caution_output_select,
	input wire o_fault_flag_out,
	input wire o_fault_code_line_1,
	input wire o_fault_code_line_2,
	input wire o_fault_code_line_3,
	input wire o_caution_flag_out,
	input wire o_power_stage_enable,
	input wire o_display_alarm,
	input wire [3:0] o_display_source
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_nrst);
	wire [3:0] s = o_display_source;
	wire [2:0] code = {o_fault_code_line_3, o_fault_code_line_2, o_fault_code_line_1};
	wire [2:0] exp_c = s == 4'h4 ? 3'h1 : (s > 4'h4 && s < 4'h8) ? 3'h3 : s == 4'h8 ? 3'h4 : 3'h0;
	sequence alarm_clears;
		$fell(o_display_alarm);
	endsequence
	// the clearing edge used run and setting as they stood three samples earlier
	sequence resume_wanted;
		$past(i_servo_on_source_select, 3) == 4'h7 || $past(i_run, 3);
	endsequence
	a_flag_low_alarm: assert property (o_display_alarm |-> !o_fault_flag_out) else $error("flag on in alarm");
	a_power_off_alarm: assert property (o_display_alarm |-> !o_power_stage_enable) else $error("power on in alarm");
	a_fault_raises: assert property (|i_fault_detect |-> ##[1:6] o_display_alarm) else $error("no alarm");
	a_code_match: assert property (o_display_alarm |-> code == exp_c) else $error("bad code");
	a_code_held: assert property (o_display_alarm && $past(o_display_alarm) |-> $stable({code, s})) else $error("code moved");
	a_power_only: assert property (o_display_alarm && (s == 4'h0 || s == 4'h2 || s == 4'h4)
		|=> o_display_alarm) else $error("power-only alarm cleared");
	a_caution_off: assert property ((!i_caution_output_select)[*4] |-> !o_caution_flag_out) else $error("warn flag");
	a_resume_drive: assert property (alarm_clears ##0 resume_wanted |-> o_power_stage_enable)
		else $error("no resume");
endmodule
bind servo_alarm_reporting servo_alarm_properties chk (.i_ref_clk, .i_nrst, .i_fault_detect, .i_run,
	.i_servo_on_source_select, .i_caution_output_select, .o_fault_flag_out, .o_fault_code_line_1,
	.o_fault_code_line_2, .o_fault_code_line_3, .o_caution_flag_out, .o_power_stage_enable,
	.o_display_alarm, .o_display_source);

// >>> tb/host_ctrl_model.sv
// host sequence controller driving run and alarm reset
`timescale 1ns/1ps
module host_ctrl_model (
	input wire i_ref_clk,
	input wire i_cancel,
	input wire i_want_run,
	output reg o_run,
	output reg o_alarm_reset
);
	initial begin
		o_run = 0;
		o_alarm_reset = 0;
	end
	// run is dropped a cycle before the reset request so the drive cannot restart mid-cancel
	always @(negedge i_ref_clk) begin
		o_run <= i_want_run && !i_cancel;
		o_alarm_reset <= i_cancel && !o_run;
	end
endmodule

// >>> tb/servo_alarm_reporting_bench.sv
// bench for the servo alarm block
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_total++; $display("Error t=%0t got %h exp %h", $time, a, b); end end
module servo_alarm_reporting_bench;
	reg clk = 0, nrst = 0, warn = 0, krst = 0, up = 0, dn = 0, cout = 0, cen = 0, cancel = 0, want = 0;
	reg [8:0] flt = 0;
	reg [3:0] sel = 0;
	reg [2:0] wc = 0;
	wire run, arst, ff, l1, l2, l3, cf, pe, da, dw;
	wire [3:0] ds;
	int err_total = 0, tests_run = 0, s;
	always #10 clk = ~clk;
	host_ctrl_model hm (.i_ref_clk(clk), .i_cancel(cancel), .i_want_run(want), .o_run(run), .o_alarm_reset(arst));
	servo_alarm_reporting uut (.i_ref_clk(clk), .i_nrst(nrst), .i_fault_detect(flt), .i_warn_detect(warn),
		.i_warn_code(wc), .i_alarm_reset(arst), .i_key_reset(krst), .i_key_up(up), .i_key_down(dn), .i_run(run),
		.i_servo_on_source_select(sel), .i_caution_output_select(cout), .i_caution_code_enable(cen),
		.o_fault_flag_out(ff), .o_fault_code_line_1(l1), .o_fault_code_line_2(l2), .o_fault_code_line_3(l3),
		.o_caution_flag_out(cf), .o_power_stage_enable(pe), .o_display_alarm(da), .o_display_warning(dw),
		.o_display_source(ds));
	function logic [2:0] exp_code(int c);
		return c == 4 ? 3'h1 : (c > 4 && c < 8) ? 3'h3 : c == 8 ? 3'h4 : 3'h0;
	endfunction
	task step(int n);
		repeat (n) @(negedge clk);
	endtask
	task cancel_by(int m);
		if (m == 0) cancel <= 1;
		else if (m == 1) krst = 1;
		else begin
			up = 1;
			dn = 1;
		end
		step(6);
		cancel <= 0;
		{krst, up, dn} = 0;
		step(6);
	endtask
	task give_verdict;
		$display("errors %0d tests %0d", err_total, tests_run);
		if (err_total == 0 && tests_run > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		step(20);
		nrst = 1;
		step(3);
		for (s = 0; s < 9; s++) begin
			want <= (s != 8);
			flt[s] = 1;
			step(6);
			flt = 0;
			// source gone: outputs must still show the alarm
			step(6);
			`CHK(ff, 1'b0)
			`CHK({da, pe, ds}, {2'b10, 4'(s)})
			`CHK({l3, l2, l1}, exp_code(s))
			sel = (s == 8) ? 4'h7 : 4'h0;
			cancel_by(s % 3);
			if (s == 0 || s == 2 || s == 4) begin
				`CHK(da, 1'b1)
				nrst = 0;
				step(2);
				nrst = 1;
				step(6);
			end
			`CHK({da, ff, pe}, 3'b011)
		end
		sel = 0;
		want <= 1;
		warn = 1;
		wc = 3'h5;
		cout = 1;
		cen = 1;
		step(6);
		`CHK({dw, cf, l3, l2, l1, pe}, 6'h3B)
		want <= 0;
		{cout, cen} = 0;
		step(6);
		`CHK({cf, l3, l2, l1, pe}, 5'h00)
		give_verdict;
	end
endmodule
